// *** rtl/hts_pkg.sv ***
// Purpose: Shared constants and types for the humidity/temperature serial target.
// Assumes: 50 MHz core clock, serial clock driven by the external controller.
// Notes:   Conversion times are kept in nanoseconds; cycle counts derive from them.
package hts_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned RESET_MIN_NS  = 1000;

  // Conversion times per resolution code, finest code last.
  localparam int unsigned HUM_NS_0  = 1_110_000;
  localparam int unsigned HUM_NS_1  = 2_140_000;
  localparam int unsigned HUM_NS_2  = 4_210_000;
  localparam int unsigned HUM_NS_3  = 8_340_000;
  localparam int unsigned TEMP_NS_0 = 1_570_000;
  localparam int unsigned TEMP_NS_1 = 3_060_000;
  localparam int unsigned TEMP_NS_2 = 6_030_000;
  localparam int unsigned TEMP_NS_3 = 11_980_000;

  localparam int unsigned CNT_W = 21;
  typedef logic [CNT_W-1:0] hts_cnt_t;

  // Target address: strap pin drives the least significant bit.
  localparam logic [6:0] ADDR_BASE = 7'h40;

  // Command byte layout.
  localparam logic [2:0] CMD_CONV_PAT = 3'h2;
  localparam int unsigned CMD_PAT_HI  = 7;
  localparam int unsigned CMD_PAT_LO  = 5;
  localparam int unsigned CMD_HUM_HI  = 4;
  localparam int unsigned CMD_HUM_LO  = 3;
  localparam int unsigned CMD_TEMP_HI = 2;
  localparam int unsigned CMD_TEMP_LO = 1;
  localparam logic [7:0] CMD_READ_ALL = 8'h00;
  localparam logic [7:0] CMD_READ_HUM = 8'h10;

  // Byte positions inside a result record.
  localparam logic [2:0] IDX_TEMP_FIRST = 3'h0;
  localparam logic [2:0] IDX_HUM_FIRST  = 3'h3;
  localparam logic [2:0] IDX_LAST       = 3'h5;
  localparam logic [3:0] BIT_ACK        = 4'h8;
  localparam logic [3:0] BIT_LAST_DATA  = 4'h7;
  localparam logic [7:0] IDLE_BYTE      = 8'hFF;

  localparam logic [7:0] CRC_POLY_DEF = 8'h31;
  localparam logic [7:0] CRC_INIT_DEF = 8'h00;

  typedef struct packed {
    logic [15:0] temp;
    logic [7:0]  temp_crc;
    logic [15:0] hum;
    logic [7:0]  hum_crc;
  } hts_rec_t;

endpackage

// *** rtl/hts_target.sv ***
// Purpose: Serial target front end with conversion timing and result record.
// Assumes: scl_i is a clock port; sda_i is the resolved data line level.
// Notes:   Serial side runs only on serial clock edges and data line falling edges, so it never waits on time.
`timescale 1ns/1ps
`default_nettype none

module hts_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             push;
  logic             pop;

  assign in_ready  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_ff[rd_ptr_ff];

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module hts_target
  import hts_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH  = 16,
  parameter bit          ALT_ADDR_EN = 1'b0,
  parameter logic [6:0]  ALT_ADDR    = 7'h7F,
  parameter logic [7:0]  CRC_POLY    = CRC_POLY_DEF,
  parameter logic [7:0]  CRC_INIT    = CRC_INIT_DEF,
  parameter int unsigned HUM_CYC_0   = HUM_NS_0 / CLK_PERIOD_NS,
  parameter int unsigned HUM_CYC_1   = HUM_NS_1 / CLK_PERIOD_NS,
  parameter int unsigned HUM_CYC_2   = HUM_NS_2 / CLK_PERIOD_NS,
  parameter int unsigned HUM_CYC_3   = HUM_NS_3 / CLK_PERIOD_NS,
  parameter int unsigned TEMP_CYC_0  = TEMP_NS_0 / CLK_PERIOD_NS,
  parameter int unsigned TEMP_CYC_1  = TEMP_NS_1 / CLK_PERIOD_NS,
  parameter int unsigned TEMP_CYC_2  = TEMP_NS_2 / CLK_PERIOD_NS,
  parameter int unsigned TEMP_CYC_3  = TEMP_NS_3 / CLK_PERIOD_NS
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        address_strap_pin,
  input  wire logic [15:0] temp_sample,
  input  wire logic [15:0] hum_sample,
  output logic             conv_busy
);
  import hts_pkg::*;

  typedef enum logic [2:0] {
    SER_IDLE   = 3'b000,
    SER_ADDR   = 3'b001,
    SER_CMD    = 3'b010,
    SER_READ   = 3'b011,
    SER_IGNORE = 3'b100
  } hts_ser_t;

  typedef enum logic [1:0] {
    CV_IDLE = 2'b00,
    CV_RUN  = 2'b01,
    CV_PUSH = 2'b10
  } hts_cv_t;

  function automatic logic [7:0] crc8(input logic [15:0] data);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--)
    begin
      c = (c[7] ^ data[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  function automatic logic [7:0] rec_byte(input hts_rec_t r, input logic [2:0] idx);
    logic [7:0] b;
    case (idx)
      3'h0:    b = r.temp[15:8];
      3'h1:    b = r.temp[7:0];
      3'h2:    b = r.temp_crc;
      3'h3:    b = r.hum[15:8];
      3'h4:    b = r.hum[7:0];
      3'h5:    b = r.hum_crc;
      default: b = IDLE_BYTE;
    endcase
    return b;
  endfunction

  // Core clock domain reset copy.
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // Start detection: data falling while the serial clock is high.
  logic start_tog_ff;

  always_ff @(negedge sda_i or negedge resetn)
  begin
    if (!resetn)
    begin
      start_tog_ff <= 1'b0;
    end
    else if (scl_i)
    begin
      start_tog_ff <= ~start_tog_ff;
    end
  end

  // Serial clock domain, rising edge: sampling and sequencing.
  hts_ser_t   state_ff;
  logic       start_seen_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [2:0] idx_ff;
  logic [2:0] ptr_ff;
  logic [7:0] cmd_ff;
  logic       cmd_tog_ff;
  logic       strap_meta_ff;
  logic       strap_ff;
  logic       rec_meta_ff;
  logic       rec_sync_ff;
  logic       ack_tog_ff;
  hts_rec_t   rec_scl_ff;
  hts_rec_t   rec_ff;
  logic       rec_tog_ff;
  logic [6:0] strap_addr;
  logic       addr_hit;

  assign strap_addr = {ADDR_BASE[6:1], strap_ff};
  assign addr_hit   = (shift_ff[6:0] == strap_addr) ||
                      (ALT_ADDR_EN && (shift_ff[6:0] == ALT_ADDR));

  // Strap and record handover pass two serial-clock flops before use.
  always_ff @(posedge scl_i or negedge resetn)
  begin
    if (!resetn)
    begin
      strap_meta_ff <= 1'b0;
      strap_ff      <= 1'b0;
      rec_meta_ff   <= 1'b0;
      rec_sync_ff   <= 1'b0;
      ack_tog_ff    <= 1'b0;
      rec_scl_ff    <= '0;
    end
    else
    begin
      strap_meta_ff <= address_strap_pin;
      strap_ff      <= strap_meta_ff;
      rec_meta_ff   <= rec_tog_ff;
      rec_sync_ff   <= rec_meta_ff;
      if (rec_sync_ff != ack_tog_ff)
      begin
        rec_scl_ff <= rec_ff;
        ack_tog_ff <= rec_sync_ff;
      end
    end
  end

  // Every step is triggered by a serial clock edge; nothing counts time here.
  always_ff @(posedge scl_i or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff      <= SER_IDLE;
      start_seen_ff <= 1'b0;
      bit_cnt_ff    <= '0;
      shift_ff      <= '0;
      idx_ff        <= '0;
      ptr_ff        <= IDX_TEMP_FIRST;
      cmd_ff        <= '0;
      cmd_tog_ff    <= 1'b0;
    end
    else if (start_seen_ff != start_tog_ff)
    begin
      start_seen_ff <= start_tog_ff;
      shift_ff      <= {7'h00, sda_i};
      bit_cnt_ff    <= 4'h1;
      state_ff      <= SER_ADDR;
    end
    else if (state_ff != SER_IDLE && state_ff != SER_IGNORE)
    begin
      if (bit_cnt_ff != BIT_ACK)
      begin
        shift_ff   <= {shift_ff[6:0], sda_i};
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
        if (bit_cnt_ff == BIT_LAST_DATA && state_ff == SER_ADDR && !addr_hit)
        begin
          state_ff <= SER_IGNORE;
        end
        if (bit_cnt_ff == BIT_LAST_DATA && state_ff == SER_CMD)
        begin
          cmd_ff     <= {shift_ff[6:0], sda_i};
          cmd_tog_ff <= ~cmd_tog_ff;
          if ({shift_ff[6:0], sda_i} == CMD_READ_ALL)
          begin
            ptr_ff <= IDX_TEMP_FIRST;
          end
          else if ({shift_ff[6:0], sda_i} == CMD_READ_HUM)
          begin
            ptr_ff <= IDX_HUM_FIRST;
          end
        end
      end
      else
      begin
        bit_cnt_ff <= '0;
        case (state_ff)
          SER_ADDR:
          begin
            state_ff <= shift_ff[0] ? SER_READ : SER_CMD;
            idx_ff   <= ptr_ff;
          end
          SER_READ:
          begin
            if (sda_i)
            begin
              state_ff <= SER_IDLE;
            end
            else if (idx_ff <= IDX_LAST)
            begin
              idx_ff <= idx_ff + 3'h1;
            end
          end
          default:
          begin
            state_ff <= state_ff;
          end
        endcase
      end
    end
  end

  // Serial clock domain, falling edge: the data line changes only here.
  logic       nxt_oe;
  logic [7:0] tx_byte;

  always_comb
  begin
    nxt_oe  = 1'b0;
    tx_byte = rec_byte(rec_scl_ff, idx_ff);
    if ((state_ff == SER_ADDR || state_ff == SER_CMD) && bit_cnt_ff == BIT_ACK)
    begin
      nxt_oe = 1'b1;
    end
    else if (state_ff == SER_READ && bit_cnt_ff != BIT_ACK)
    begin
      nxt_oe = ~tx_byte[3'(BIT_LAST_DATA - bit_cnt_ff)];
    end
  end

  always_ff @(negedge scl_i or negedge resetn)
  begin
    if (!resetn)
    begin
      sda_oe <= 1'b0;
    end
    else
    begin
      sda_oe <= nxt_oe;
    end
  end

  assign sda_o = 1'b0;

  // Command handover into the core clock domain.
  logic cmd_meta_ff;
  logic cmd_sync_ff;
  logic cmd_seen_ff;
  logic cmd_event;

  always_ff @(posedge clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      cmd_meta_ff <= 1'b0;
      cmd_sync_ff <= 1'b0;
      cmd_seen_ff <= 1'b0;
    end
    else
    begin
      cmd_meta_ff <= cmd_tog_ff;
      cmd_sync_ff <= cmd_meta_ff;
      cmd_seen_ff <= cmd_sync_ff;
    end
  end

  assign cmd_event = cmd_sync_ff != cmd_seen_ff;

  // Conversion engine.
  hts_cv_t  cv_ff;
  hts_cnt_t timer_ff;
  hts_cnt_t hum_cyc;
  hts_cnt_t temp_cyc;
  hts_rec_t res_ff;
  logic [2:0] push_idx_ff;
  logic       fifo_in_ready;
  logic       conv_cmd;

  assign conv_cmd = cmd_event && (cmd_ff[CMD_PAT_HI:CMD_PAT_LO] == CMD_CONV_PAT);

  always_comb
  begin
    case (cmd_ff[CMD_HUM_HI:CMD_HUM_LO])
      2'b00:   hum_cyc = CNT_W'(HUM_CYC_0);
      2'b01:   hum_cyc = CNT_W'(HUM_CYC_1);
      2'b10:   hum_cyc = CNT_W'(HUM_CYC_2);
      default: hum_cyc = CNT_W'(HUM_CYC_3);
    endcase
    case (cmd_ff[CMD_TEMP_HI:CMD_TEMP_LO])
      2'b00:   temp_cyc = CNT_W'(TEMP_CYC_0);
      2'b01:   temp_cyc = CNT_W'(TEMP_CYC_1);
      2'b10:   temp_cyc = CNT_W'(TEMP_CYC_2);
      default: temp_cyc = CNT_W'(TEMP_CYC_3);
    endcase
  end

  // A command during a running conversion is dropped rather than restarting it.
  always_ff @(posedge clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      cv_ff       <= CV_IDLE;
      timer_ff    <= '0;
      res_ff      <= '0;
      push_idx_ff <= '0;
    end
    else
    begin
      case (cv_ff)
        CV_IDLE:
        begin
          if (conv_cmd)
          begin
            timer_ff <= hum_cyc + temp_cyc - 1'b1;
            cv_ff    <= CV_RUN;
          end
        end
        CV_RUN:
        begin
          if (timer_ff == '0)
          begin
            res_ff.temp     <= temp_sample;
            res_ff.temp_crc <= crc8(temp_sample);
            res_ff.hum      <= hum_sample;
            res_ff.hum_crc  <= crc8(hum_sample);
            push_idx_ff     <= '0;
            cv_ff           <= CV_PUSH;
          end
          else
          begin
            timer_ff <= timer_ff - 1'b1;
          end
        end
        CV_PUSH:
        begin
          if (fifo_in_ready)
          begin
            push_idx_ff <= push_idx_ff + 3'h1;
            if (push_idx_ff == IDX_LAST)
            begin
              cv_ff <= CV_IDLE;
            end
          end
        end
        default:
        begin
          cv_ff <= CV_IDLE;
        end
      endcase
    end
  end

  assign conv_busy = (cv_ff != CV_IDLE);

  // Result bytes queue toward the publisher.
  logic [7:0] fifo_out_data;
  logic       fifo_out_valid;
  logic       fifo_out_ready;

  hts_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n_ff),
    .in_data   (rec_byte(res_ff, push_idx_ff)),
    .in_valid  (cv_ff == CV_PUSH),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready)
  );

  // Publisher: the record stays frozen until the serial side has taken it.
  logic [7:0] stage_ff [6];
  logic [2:0] stage_cnt_ff;
  logic       ack_meta_ff;
  logic       ack_sync_ff;

  assign fifo_out_ready = (stage_cnt_ff <= IDX_LAST);

  always_ff @(posedge clk or negedge rst_n_ff)
  begin
    if (!rst_n_ff)
    begin
      stage_cnt_ff <= '0;
      ack_meta_ff  <= 1'b0;
      ack_sync_ff  <= 1'b0;
      rec_ff       <= '0;
      rec_tog_ff   <= 1'b0;
      for (int i = 0; i < 6; i++)
      begin
        stage_ff[i] <= '0;
      end
    end
    else
    begin
      ack_meta_ff <= ack_tog_ff;
      ack_sync_ff <= ack_meta_ff;
      if (fifo_out_valid && fifo_out_ready)
      begin
        stage_ff[stage_cnt_ff] <= fifo_out_data;
        stage_cnt_ff           <= stage_cnt_ff + 3'h1;
      end
      else if (stage_cnt_ff > IDX_LAST && ack_sync_ff == rec_tog_ff)
      begin
        rec_ff       <= {stage_ff[0], stage_ff[1], stage_ff[2],
                         stage_ff[3], stage_ff[4], stage_ff[5]};
        rec_tog_ff   <= ~rec_tog_ff;
        stage_cnt_ff <= '0;
      end
    end
  end

endmodule

`default_nettype wire

// *** verification/hts_target_asserts.sv ***
// Purpose: Port checks for the serial target.
// Assumes: Conversion counts are handed on from the bound instance.
// Notes:   Busy length is measured by a helper counter in the core domain.
`timescale 1ns/1ps
`default_nettype none
module hts_chk #(
  parameter int unsigned HUM_CYC_0  = 20,
  parameter int unsigned HUM_CYC_3  = 20,
  parameter int unsigned TEMP_CYC_0 = 20,
  parameter int unsigned TEMP_CYC_3 = 20
) (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic        address_strap_pin,
  input wire logic [15:0] temp_sample,
  input wire logic [15:0] hum_sample,
  input wire logic        conv_busy
);
  logic        oe_rise_ff;
  logic [23:0] busy_cnt_ff;
  always_ff @(posedge scl_i or negedge resetn)
  begin
    if (!resetn)
      oe_rise_ff <= 1'b0;
    else
      oe_rise_ff <= sda_oe;
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      busy_cnt_ff <= 24'h00_0000;
    else if (!conv_busy)
      busy_cnt_ff <= 24'h00_0000;
    else
      busy_cnt_ff <= busy_cnt_ff + 24'h00_0001;
  end
  sequence s_busy_young;
    conv_busy && (busy_cnt_ff < 24'(HUM_CYC_0 + TEMP_CYC_0));
  endsequence
  sequence s_released;
    $rose(resetn);
  endsequence
  property p_busy_min;
    @(posedge clk) disable iff (!resetn) s_busy_young |=> conv_busy;
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("conversion ended early");
  property p_busy_max;
    @(posedge clk) disable iff (!resetn)
      conv_busy |-> busy_cnt_ff < 24'(HUM_CYC_3 + TEMP_CYC_3 + 100);
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("conversion too long");
  property p_oe_hold;
    @(negedge scl_i) disable iff (!resetn) sda_oe == oe_rise_ff;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("bit moved while clock high");
  property p_drive_low;
    @(posedge scl_i) disable iff (!resetn) sda_oe |-> !sda_i && !sda_o;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("driven bit not on wire");
  property p_sdo_const;
    @(posedge clk) sda_o == 1'b0;
  endproperty
  a_sdo_const: assert property (p_sdo_const) else $error("data pad not open drain");
  property p_rst_oe;
    @(posedge clk) !resetn |-> !sda_oe;
  endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("data line held in reset");
  property p_rst_busy;
    @(posedge clk) !resetn |-> !conv_busy;
  endproperty
  a_rst_busy: assert property (p_rst_busy) else $error("busy during reset");
  property p_wake_idle;
    @(posedge clk) s_released |-> !conv_busy ##1 !conv_busy;
  endproperty
  a_wake_idle: assert property (p_wake_idle) else $error("busy after reset");
endmodule
bind hts_target hts_chk #(.HUM_CYC_0(HUM_CYC_0), .HUM_CYC_3(HUM_CYC_3),
  .TEMP_CYC_0(TEMP_CYC_0), .TEMP_CYC_3(TEMP_CYC_3)) u_chk (.clk(clk), .resetn(resetn),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .address_strap_pin(address_strap_pin), .temp_sample(temp_sample),
  .hum_sample(hum_sample), .conv_busy(conv_busy));
`default_nettype wire

// *** verification/hts_host.sv ***
// Purpose: Serial controller model that faces the target.
// Assumes: Pull-up on the data wire, resolved by the bench.
// Notes:   Clock stands high outside frames; q stretches every phase.
`timescale 1ns/1ps
`default_nettype none
module hts_host (
  output logic      scl,
  output logic      oe,
  input  wire logic sda
);
  int q = 1;
  initial
  begin
    scl = 1'b1;
    oe = 1'b0;
  end
  task automatic start();
    oe = 1'b0;
    #(4*q) scl = 1'b1;
    #(16*q) oe = 1'b1;
    #(16*q) scl = 1'b0;
  endtask
  task automatic stop();
    #(4*q) oe = 1'b1;
    #(12*q) scl = 1'b1;
    #(16*q) oe = 1'b0;
    #(16*q);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      #(4*q) oe = !d[i]; // data moves only while the clock is low
      #(12*q) scl = 1'b1;
      #(16*q) scl = 1'b0;
    end
    #(4*q) oe = 1'b0;
    #(12*q) scl = 1'b1;
    ack = !sda;
    #(16*q) scl = 1'b0;
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] d);
    #(4*q) oe = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      #(12*q) scl = 1'b1;
      d[i] = sda;
      #(16*q) scl = 1'b0;
      #(4*q);
    end
    oe = !last; // the last byte is refused so the target lets go
    #(12*q) scl = 1'b1;
    #(16*q) scl = 1'b0;
    #(4*q) oe = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** verification/hts_target_tb_top.sv ***
// Purpose: Self-checking bench for the serial target.
// Assumes: Conversion counts shrunk so the run stays short.
// Notes:   Busy length is measured from the first cycle it is seen high.
`timescale 1ns/1ps
`default_nettype none
module hts_target_tb_top;
  import hts_pkg::*;
  localparam int HC [4] = '{40, 60, 80, 100};
  localparam int TC [4] = '{50, 70, 90, 110};
  logic        clk;
  logic        resetn;
  logic        strap;
  logic [15:0] temp_s;
  logic [15:0] hum_s;
  logic        sda_oe;
  logic        conv_busy;
  logic        scl;
  logic        host_oe;
  wire logic   sda;
  integer      seed;
  int          bad_count;
  int          compares;
  assign sda = !(sda_oe || host_oe);
  hts_host host (.scl(scl), .oe(host_oe), .sda(sda));
  hts_target #(.HUM_CYC_0(HC[0]), .HUM_CYC_1(HC[1]), .HUM_CYC_2(HC[2]), .HUM_CYC_3(HC[3]),
    .TEMP_CYC_0(TC[0]), .TEMP_CYC_1(TC[1]), .TEMP_CYC_2(TC[2]), .TEMP_CYC_3(TC[3])) uut (
    .clk(clk), .resetn(resetn), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
    .address_strap_pin(strap), .temp_sample(temp_s), .hum_sample(hum_s),
    .conv_busy(conv_busy));
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic clks(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  function automatic logic [7:0] crc8(input logic [15:0] v);
    logic [7:0] c;
    c = CRC_INIT_DEF;
    for (int i = 15; i >= 0; i--)
      c = (c[7] ^ v[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY_DEF) : {c[6:0], 1'b0};
    return c;
  endfunction
  task automatic send(input logic [6:0] a, input logic [7:0] c, output logic ack);
    logic ak;
    host.start();
    host.wr_byte({a, 1'b0}, ack);
    if (ack)
      host.wr_byte(c, ak);
    ack = ack && ak;
    host.stop();
  endtask
  task automatic fetch(input logic [6:0] a, input logic [7:0] c, input int n,
                       output logic [47:0] got);
    logic       ack;
    logic [7:0] b;
    got = '0;
    send(a, c, ack);
    check("read command ack", ack, 1'b1);
    host.start();
    host.wr_byte({a, 1'b1}, ack);
    check("read address ack", ack, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      host.rd_byte(i == n - 1, b);
      got = {got[39:0], b};
    end
    host.stop();
  endtask
  task automatic wait_busy(input logic lvl, output int n);
    for (n = 0; n < 3000 && conv_busy !== lvl; n++)
      clks(1);
    if (n == 3000)
    begin
      bad_count++;
      complete_run();
    end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = !clk;
  end
  initial
  begin
    logic        ack;
    logic [1:0]  h;
    logic [1:0]  t;
    int          n;
    logic [47:0] got;
    hts_rec_t    exp;
    seed = 32'h9c88_082e;
    bad_count = 0;
    compares = 0;
    resetn = 1'b0;
    strap = 1'b0;
    temp_s = 16'h0000;
    hum_s = 16'h0000;
    clks(10);
    resetn = 1'b1;
    clks(5);
    for (int i = 0; i < 4; i++)
    begin
      clks(1);
      strap = i[0]; // held steady through every transaction
      h = 2'(i);
      t = 2'(3 - i);
      temp_s = 16'($random(seed));
      hum_s = 16'($random(seed));
      exp = '{temp_s, crc8(temp_s), hum_s, crc8(hum_s)};
      send({ADDR_BASE[6:1], !strap}, 8'h5e, ack);
      check("foreign address ack", ack, 1'b0);
      send({ADDR_BASE[6:1], strap}, {3'b010, h, t, 1'b0}, ack);
      check("conversion ack", ack, 1'b1);
      wait_busy(1'b1, n);
      wait_busy(1'b0, n);
      check("conversion length", (n + 10 >= HC[h] + TC[t]) && (n <= HC[h] + TC[t] + 100),
        1'b1);
      clks(1);
      temp_s = 16'($random(seed));
      hum_s = 16'($random(seed));
      fetch({ADDR_BASE[6:1], strap}, CMD_READ_ALL, 6, got);
      check("combined read", got, exp);
      fetch({ADDR_BASE[6:1], strap}, CMD_READ_HUM, 3, got);
      check("humidity read", got[23:0], exp[23:0]);
      $display("test conversion %0d done", i);
    end
    send(7'h7f, CMD_READ_ALL, ack);
    check("alternate address ack", ack, 1'b0);
    send({ADDR_BASE[6:1], strap}, 8'h5e, ack);
    wait_busy(1'b1, n);
    host.start();
    host.wr_byte({ADDR_BASE[6:1], strap, 1'b1}, ack);
    host.rd_byte(1'b0, got[7:0]);
    clks(1);
    resetn = 1'b0;
    clks(50);
    check("data line in reset", sda_oe, 1'b0);
    check("busy in reset", conv_busy, 1'b0);
    resetn = 1'b1;
    clks(5);
    host.q = 40;
    send({ADDR_BASE[6:1], strap}, CMD_READ_HUM, ack);
    check("slow clock ack", ack, 1'b1);
    $display("test reset and slow clock done");
    complete_run();
  end
endmodule
`default_nettype wire
